// file: rtl/gtm_pkg.sv
/*
 Package for the general timer module register block: offsets, field positions,
 reset values, mode encodings and the packed register layouts.
 Assumes a 32-bit APB slave with word-aligned registers.
*/
package gtm_pkg;

   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [11:0] OFF_CONFIG = 12'h000;
   localparam logic [11:0] OFF_A_MODE = 12'h004;
   localparam logic [11:0] OFF_B_MODE = 12'h008;
   localparam logic [11:0] OFF_CONTROL = 12'h00c;
   localparam logic [11:0] OFF_IRQ_MASK = 12'h018;
   localparam logic [11:0] OFF_RAW_IRQ = 12'h01c;
   localparam logic [11:0] OFF_MASKED_IRQ = 12'h020;
   localparam logic [11:0] OFF_IRQ_CLEAR = 12'h024;

   // ----------------------------------------
   // Writable bit masks and reset values
   // ----------------------------------------
   localparam logic [31:0] CONFIG_WMASK = 32'h0000_0007;
   localparam logic [31:0] MODE_WMASK = 32'h0000_000f;
   localparam logic [31:0] CONTROL_WMASK = 32'h0000_6f7f;
   localparam logic [31:0] IRQ_WMASK = 32'h0000_070f;
   localparam logic [31:0] REG_RESET = 32'h0000_0000;

   // ----------------------------------------
   // Control field positions
   // ----------------------------------------
   localparam int CTL_A_EN = 0;
   localparam int CTL_A_STALL = 1;
   localparam int CTL_A_EDGE_LO = 2;
   localparam int CTL_RTC_EN = 4;
   localparam int CTL_A_TRIG = 5;
   localparam int CTL_A_PWM_INV = 6;
   localparam int CTL_B_EN = 8;
   localparam int CTL_B_STALL = 9;
   localparam int CTL_B_EDGE_LO = 10;
   localparam int CTL_B_TRIG = 13;
   localparam int CTL_B_PWM_INV = 14;

   // ----------------------------------------
   // Interrupt bit positions
   // ----------------------------------------
   localparam int IRQ_A_TIMEOUT = 0;
   localparam int IRQ_A_CAP_MATCH = 1;
   localparam int IRQ_A_CAP_EVENT = 2;
   localparam int IRQ_REALTIME = 3;
   localparam int IRQ_B_TIMEOUT = 8;
   localparam int IRQ_B_CAP_MATCH = 9;
   localparam int IRQ_B_CAP_EVENT = 10;

   // ----------------------------------------
   // Encodings
   // ----------------------------------------
   typedef enum logic [2:0] {
      GTM_CFG_32BIT = 3'h0,
      GTM_CFG_REALTIME = 3'h1,
      GTM_CFG_RESERVED = 3'h2,
      GTM_CFG_16BIT = 3'h4
   } gtm_cfg_e;

   typedef enum logic [1:0] {
      GTM_MODE_RESERVED = 2'h0,
      GTM_MODE_ONE_SHOT = 2'h1,
      GTM_MODE_PERIODIC = 2'h2,
      GTM_MODE_CAPTURE = 2'h3
   } gtm_mode_e;

   typedef enum logic [1:0] {
      GTM_EDGE_POS = 2'h0,
      GTM_EDGE_NEG = 2'h1,
      GTM_EDGE_RSVD = 2'h2,
      GTM_EDGE_BOTH = 2'h3
   } gtm_edge_e;

   // Mode register layout, shared by both halves
   typedef struct packed {
      logic alternate_select;
      logic capture_kind;
      logic [1:0] mode_field;
   } gtm_mode_s;

   // Decoded per-half controls handed to the datapath
   typedef struct packed {
      logic one_shot;
      logic periodic;
      logic edge_count;
      logic edge_time;
      logic pwm;
      logic run;
      logic stall_enable;
      logic pos_edge;
      logic neg_edge;
      logic trigger_enable;
      logic pwm_invert;
   } gtm_half_s;

endpackage : gtm_pkg

// file: rtl/gtm_regs.sv
/*
 Configuration, mode, control and interrupt register block of the general timer
 module, with an APB slave and decoded controls for the two timer halves.
 Assumes a single clock, and event pulses from the counting datapath outside.
*/
// Operation
// - Decode config code: 32-bit, realtime, 16-bit pair
// - Decode mode field, alternate and capture kind
// - Second half owns an identical mode register
// - Enable bits start or stop each half
// - Stall enable bit per half
// - Edge field picks positive, negative, both
// - Control bit four gates realtime counting
// - Trigger output enabled only by its bit
// - PWM level bit inverts PWM output
// - Mask bits enable interrupts, reset zero
// - Seven mask bits at documented positions
// - Raw status sets regardless of mask
// - Raw bit holds until cleared by one
// - Masked bit is raw and mask; drives irq
// - Clear writes one clear, zero ignored
module gtm_regs (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic [10:0] event_in,
   input wire logic a_pwm_raw_in,
   input wire logic b_pwm_raw_in,
   input wire logic a_trigger_raw_in,
   input wire logic b_trigger_raw_in,
   output logic [2:0] config_select_out,
   output logic mode_32bit_out,
   output logic mode_realtime_out,
   output logic mode_16bit_out,
   output logic realtime_count_enable_out,
   output gtm_pkg::gtm_half_s a_half_out,
   output gtm_pkg::gtm_half_s b_half_out,
   output logic a_pwm_out,
   output logic b_pwm_out,
   output logic a_trigger_out,
   output logic b_trigger_out,
   output logic irq_out
);

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [31:0] config_reg;
   logic [31:0] first_half_mode_reg;
   logic [31:0] second_half_mode_reg;
   logic [31:0] control_reg;
   logic [31:0] irq_mask_reg;
   logic [31:0] raw_irq_reg;
   logic [31:0] raw_irq_next;
   logic [31:0] rdata_next;

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   wire logic access = psel_in & penable_in;
   wire logic wr = access & pwrite_in;
   // Read data is taken in the setup phase, so it stands through the access phase
   wire logic rd = psel_in & ~penable_in & ~pwrite_in;
   wire logic hit_cfg = paddr_in == gtm_pkg::OFF_CONFIG;
   wire logic hit_amode = paddr_in == gtm_pkg::OFF_A_MODE;
   wire logic hit_bmode = paddr_in == gtm_pkg::OFF_B_MODE;
   wire logic hit_ctl = paddr_in == gtm_pkg::OFF_CONTROL;
   wire logic hit_mask = paddr_in == gtm_pkg::OFF_IRQ_MASK;
   wire logic hit_raw = paddr_in == gtm_pkg::OFF_RAW_IRQ;
   wire logic hit_mis = paddr_in == gtm_pkg::OFF_MASKED_IRQ;
   wire logic hit_clr = paddr_in == gtm_pkg::OFF_IRQ_CLEAR;
   wire logic mapped = hit_cfg | hit_amode | hit_bmode | hit_ctl | hit_mask | hit_raw | hit_mis | hit_clr;
   wire logic [31:0] masked_irq = raw_irq_reg & irq_mask_reg;
   // Next mask, so the interrupt follows a mask write without a lag
   wire logic [31:0] irq_mask_next = (wr & hit_mask) ? (pwdata_in & gtm_pkg::IRQ_WMASK) : irq_mask_reg;

   assign pready_out = 1'b1;
   // Unmapped addresses answer with an error, read data zero
   assign pslverr_out = access & ~mapped;

   assign rdata_next = hit_cfg ? config_reg :
                       hit_amode ? first_half_mode_reg :
                       hit_bmode ? second_half_mode_reg :
                       hit_ctl ? control_reg :
                       hit_mask ? irq_mask_reg :
                       hit_raw ? raw_irq_reg :
                       hit_mis ? masked_irq :
                       32'h0000_0000;

   // Clear wins only where no new event arrives in the same cycle
   assign raw_irq_next = ((raw_irq_reg & ~((wr & hit_clr) ? pwdata_in : 32'h0000_0000))
                          | {21'h00_0000, event_in}) & gtm_pkg::IRQ_WMASK;

   // ----------------------------------------
   // Register storage
   // ----------------------------------------
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         config_reg <= gtm_pkg::REG_RESET;
         first_half_mode_reg <= gtm_pkg::REG_RESET;
         second_half_mode_reg <= gtm_pkg::REG_RESET;
         control_reg <= gtm_pkg::REG_RESET;
         irq_mask_reg <= gtm_pkg::REG_RESET;
      end else if (wr) begin
         if (hit_cfg) config_reg <= pwdata_in & gtm_pkg::CONFIG_WMASK;
         if (hit_amode) first_half_mode_reg <= pwdata_in & gtm_pkg::MODE_WMASK;
         if (hit_bmode) second_half_mode_reg <= pwdata_in & gtm_pkg::MODE_WMASK;
         if (hit_ctl) control_reg <= pwdata_in & gtm_pkg::CONTROL_WMASK;
         if (hit_mask) irq_mask_reg <= pwdata_in & gtm_pkg::IRQ_WMASK;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         raw_irq_reg <= gtm_pkg::REG_RESET;
         prdata_out <= 32'h0000_0000;
         irq_out <= 1'b0;
      end else begin
         raw_irq_reg <= raw_irq_next;
         prdata_out <= rd ? rdata_next : prdata_out;
         irq_out <= |(raw_irq_next & irq_mask_next);
      end
   end

   // ----------------------------------------
   // Configuration decode
   // ----------------------------------------
   // Reserved codes 0x2 and 0x3 select nothing, so both halves stay idle
   assign config_select_out = config_reg[2:0];
   assign mode_32bit_out = config_reg[2:0] == gtm_pkg::GTM_CFG_32BIT;
   assign mode_realtime_out = config_reg[2:0] == gtm_pkg::GTM_CFG_REALTIME;
   assign mode_16bit_out = config_reg[2];
   assign realtime_count_enable_out = mode_realtime_out & control_reg[gtm_pkg::CTL_RTC_EN];

   // ----------------------------------------
   // Per-half decode
   // ----------------------------------------
   gtm_pkg::gtm_mode_s a_mode;
   gtm_pkg::gtm_mode_s b_mode;
   logic [1:0] a_edge;
   logic [1:0] b_edge;
   logic a_active;
   logic b_active;

   assign a_mode = first_half_mode_reg[3:0];
   assign b_mode = second_half_mode_reg[3:0];
   assign a_edge = control_reg[gtm_pkg::CTL_A_EDGE_LO +: 2];
   assign b_edge = control_reg[gtm_pkg::CTL_B_EDGE_LO +: 2];
   // Timer B mode only matters in 16-bit configurations
   assign a_active = mode_32bit_out | mode_realtime_out | mode_16bit_out;
   assign b_active = mode_16bit_out;

   assign a_half_out.one_shot = a_mode.mode_field == gtm_pkg::GTM_MODE_ONE_SHOT;
   assign a_half_out.periodic = a_mode.mode_field == gtm_pkg::GTM_MODE_PERIODIC & ~a_mode.alternate_select;
   assign a_half_out.edge_count = a_mode.mode_field == gtm_pkg::GTM_MODE_CAPTURE & ~a_mode.alternate_select
                                  & ~a_mode.capture_kind;
   assign a_half_out.edge_time = a_mode.mode_field == gtm_pkg::GTM_MODE_CAPTURE & ~a_mode.alternate_select
                                 & a_mode.capture_kind;
   assign a_half_out.pwm = a_mode.alternate_select & ~a_mode.capture_kind
                           & a_mode.mode_field == gtm_pkg::GTM_MODE_PERIODIC;
   assign a_half_out.run = a_active & control_reg[gtm_pkg::CTL_A_EN];
   assign a_half_out.stall_enable = control_reg[gtm_pkg::CTL_A_STALL];
   assign a_half_out.pos_edge = a_edge == gtm_pkg::GTM_EDGE_POS | a_edge == gtm_pkg::GTM_EDGE_BOTH;
   assign a_half_out.neg_edge = a_edge == gtm_pkg::GTM_EDGE_NEG | a_edge == gtm_pkg::GTM_EDGE_BOTH;
   assign a_half_out.trigger_enable = control_reg[gtm_pkg::CTL_A_TRIG];
   assign a_half_out.pwm_invert = control_reg[gtm_pkg::CTL_A_PWM_INV];

   assign b_half_out.one_shot = b_mode.mode_field == gtm_pkg::GTM_MODE_ONE_SHOT;
   assign b_half_out.periodic = b_mode.mode_field == gtm_pkg::GTM_MODE_PERIODIC & ~b_mode.alternate_select;
   assign b_half_out.edge_count = b_mode.mode_field == gtm_pkg::GTM_MODE_CAPTURE & ~b_mode.alternate_select
                                  & ~b_mode.capture_kind;
   assign b_half_out.edge_time = b_mode.mode_field == gtm_pkg::GTM_MODE_CAPTURE & ~b_mode.alternate_select
                                 & b_mode.capture_kind;
   assign b_half_out.pwm = b_mode.alternate_select & ~b_mode.capture_kind
                           & b_mode.mode_field == gtm_pkg::GTM_MODE_PERIODIC;
   assign b_half_out.run = b_active & control_reg[gtm_pkg::CTL_B_EN];
   assign b_half_out.stall_enable = control_reg[gtm_pkg::CTL_B_STALL];
   assign b_half_out.pos_edge = b_edge == gtm_pkg::GTM_EDGE_POS | b_edge == gtm_pkg::GTM_EDGE_BOTH;
   assign b_half_out.neg_edge = b_edge == gtm_pkg::GTM_EDGE_NEG | b_edge == gtm_pkg::GTM_EDGE_BOTH;
   assign b_half_out.trigger_enable = control_reg[gtm_pkg::CTL_B_TRIG];
   assign b_half_out.pwm_invert = control_reg[gtm_pkg::CTL_B_PWM_INV];

   // ----------------------------------------
   // Output shaping
   // ----------------------------------------
   // Registered so the pins never glitch on a control write
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         a_pwm_out <= 1'b0;
         b_pwm_out <= 1'b0;
         a_trigger_out <= 1'b0;
         b_trigger_out <= 1'b0;
      end else begin
         a_pwm_out <= a_pwm_raw_in ^ control_reg[gtm_pkg::CTL_A_PWM_INV];
         b_pwm_out <= b_pwm_raw_in ^ control_reg[gtm_pkg::CTL_B_PWM_INV];
         a_trigger_out <= a_trigger_raw_in & control_reg[gtm_pkg::CTL_A_TRIG];
         b_trigger_out <= b_trigger_raw_in & control_reg[gtm_pkg::CTL_B_TRIG];
      end
   end

endmodule // gtm_regs

// file: bench/gtm_regs_monitor.sv
/* Port checker for gtm_regs.
   Assumes it is bound to gtm_regs and sees only its ports. */
module gtm_regs_monitor (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [31:0] prdata_out,
   input wire logic pslverr_out,
   input wire logic [10:0] event_in,
   input wire logic a_pwm_raw_in,
   input wire logic b_pwm_raw_in,
   input wire logic a_trigger_raw_in,
   input wire logic b_trigger_raw_in,
   input wire logic [2:0] config_select_out,
   input wire logic mode_32bit_out,
   input wire logic mode_realtime_out,
   input wire logic mode_16bit_out,
   input wire logic realtime_count_enable_out,
   input wire gtm_pkg::gtm_half_s a_half_out,
   input wire gtm_pkg::gtm_half_s b_half_out,
   input wire logic a_pwm_out,
   input wire logic b_pwm_out,
   input wire logic a_trigger_out,
   input wire logic b_trigger_out,
   input wire logic irq_out
);
   // ------
   // Relations
   // ------
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   property p_pwm;
      !$past(rst_in) |-> {a_pwm_out, b_pwm_out} ==
         ($past({a_pwm_raw_in, b_pwm_raw_in}) ^ $past({a_half_out.pwm_invert, b_half_out.pwm_invert}));
   endproperty
   a_pwm: assert property (p_pwm) else $error("pwm output level wrong");
   property p_trig;
      !$past(rst_in) |-> {a_trigger_out, b_trigger_out} ==
         ($past({a_trigger_raw_in, b_trigger_raw_in}) & $past({a_half_out.trigger_enable, b_half_out.trigger_enable}));
   endproperty
   a_trig: assert property (p_trig) else $error("trigger output wrong");
   property p_rtc;
      realtime_count_enable_out |-> mode_realtime_out;
   endproperty
   a_rtc: assert property (p_rtc) else $error("realtime count outside realtime config");
   property p_cfg;
      mode_16bit_out == config_select_out[2] && mode_32bit_out == (config_select_out == 3'h0);
   endproperty
   a_cfg: assert property (p_cfg) else $error("config decode wrong");
   property p_brun;
      b_half_out.run |-> mode_16bit_out;
   endproperty
   a_brun: assert property (p_brun) else $error("second half runs outside 16-bit config");
   property p_arun;
      a_half_out.run |-> mode_32bit_out || mode_realtime_out || mode_16bit_out;
   endproperty
   a_arun: assert property (p_arun) else $error("first half runs in reserved config");
   property p_modes;
      $onehot0({a_half_out.one_shot, a_half_out.periodic, a_half_out.edge_count, a_half_out.edge_time});
   endproperty
   a_modes: assert property (p_modes) else $error("two modes decoded at once");
   property p_irq;
      $rose(irq_out) |-> $past(|event_in) || $past(psel_in && penable_in && pwrite_in);
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt without cause");
   property p_err;
      pslverr_out |-> psel_in && penable_in;
   endproperty
   a_err: assert property (p_err) else $error("error outside access phase");
   c_irq: cover property (irq_out);
   c_pwm: cover property (b_half_out.run && a_half_out.pwm);
   c_err: cover property (pslverr_out);
endmodule // gtm_regs_monitor

bind gtm_regs gtm_regs_monitor u_mon (.clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .prdata_out,
   .pslverr_out, .event_in, .a_pwm_raw_in, .b_pwm_raw_in, .a_trigger_raw_in, .b_trigger_raw_in,
   .config_select_out, .mode_32bit_out, .mode_realtime_out, .mode_16bit_out, .realtime_count_enable_out,
   .a_half_out, .b_half_out, .a_pwm_out, .b_pwm_out, .a_trigger_out, .b_trigger_out, .irq_out);

// file: bench/gtm_regs_tb_top.sv
/* Testbench of gtm_regs: APB accesses, event pulses, compares.
   Assumes the package, design and checker compiled before it. */
module gtm_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, slverr;
   logic [11:0] paddr_in = 12'h000;
   logic [31:0] pwdata_in = 32'h0, rd, prdata_out;
   logic pready_out, pslverr_out, rce, m32, mrt, m16, irq_out;
   logic [10:0] event_in = 11'h000;
   logic [3:0] raw_in = 4'h0, outs;
   logic [2:0] cfg;
   gtm_pkg::gtm_half_s ah, bh;
   int n_fail = 0, check_count = 0, cyc = 0;
   logic [11:0] offs [8] = '{12'h0, 12'h4, 12'h8, 12'hc, 12'h18, 12'h1c, 12'h20, 12'h24};
   logic [31:0] wm [5] = '{gtm_pkg::CONFIG_WMASK, gtm_pkg::MODE_WMASK, gtm_pkg::MODE_WMASK,
      gtm_pkg::CONTROL_WMASK, gtm_pkg::IRQ_WMASK};
   logic [3:0] mv [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h7, 4'ha};
   logic [4:0] me [6] = '{5'h00, 5'h10, 5'h08, 5'h04, 5'h02, 5'h01};
   int ed [3] = '{0, 1, 3};
   always #50 clk_in = ~clk_in;
   gtm_regs uut (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
      .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
      .pready_out(pready_out), .pslverr_out(pslverr_out), .event_in(event_in), .a_pwm_raw_in(raw_in[3]),
      .b_pwm_raw_in(raw_in[2]), .a_trigger_raw_in(raw_in[1]), .b_trigger_raw_in(raw_in[0]),
      .config_select_out(cfg), .mode_32bit_out(m32), .mode_realtime_out(mrt), .mode_16bit_out(m16),
      .realtime_count_enable_out(rce), .a_half_out(ah), .b_half_out(bh), .a_pwm_out(outs[3]),
      .b_pwm_out(outs[2]), .a_trigger_out(outs[1]), .b_trigger_out(outs[0]), .irq_out(irq_out));
   // ------
   // Access tasks
   // ------
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_in);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1'b1;
      do begin
         @(posedge clk_in);
      end while (pready_out !== 1'b1);
      rd = prdata_out;
      slverr = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      @(negedge clk_in);
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), e, rd);
   endtask
   task automatic ev(input logic [10:0] v);
      @(posedge clk_in);
      event_in <= v;
      @(posedge clk_in);
      event_in <= 11'h000;
      @(negedge clk_in);
   endtask
   function automatic logic [5:0] hc(input gtm_pkg::gtm_half_s h);
      return {h.run, h.stall_enable, h.pos_edge, h.neg_edge, h.trigger_enable, h.pwm_invert};
   endfunction
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 4000) begin
         n_fail++;
         stop_test();
      end
   end
   // ------
   // Tests
   // ------
   initial begin
      repeat (20) @(posedge clk_in);
      rst_in <= 1'b0;
      foreach (offs[i]) rdchk(offs[i], 32'h0);
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, offs[i], 32'hffffffff);
         rdchk(offs[i], i < 5 ? wm[i] : 32'h0);
      end
      apb(1'b0, 12'h040, 32'h0);
      chk("slverr", 32'h1, {31'h0, slverr});
      $display("test registers done");
      for (int c = 0; c < 8; c++) begin
         apb(1'b1, 12'h000, 32'(c));
         chk("cfg", {c == 0, c == 1, c >= 4}, {m32, mrt, m16});
         chk("cfg code", 32'(c), {29'h0, cfg});
      end
      apb(1'b1, 12'h00c, 32'h0);
      foreach (mv[i]) begin
         apb(1'b1, 12'h004, {28'h0, mv[i]});
         apb(1'b1, 12'h008, {28'h0, mv[(i + 1) % 6]});
         chk("a mode", me[i], {ah.one_shot, ah.periodic, ah.edge_count, ah.edge_time, ah.pwm});
         chk("b mode", me[(i + 1) % 6], {bh.one_shot, bh.periodic, bh.edge_count, bh.edge_time, bh.pwm});
      end
      $display("test modes done");
      for (int h = 0; h < 2; h++)
         foreach (ed[j]) begin
            apb(1'b1, 12'h00c, (32'h63 | (ed[j] << 2)) << (8 * h));
            chk("own half", {2'h3, ed[j] != 1, ed[j] != 0, 2'h3}, h ? hc(bh) : hc(ah));
            chk("other half", 6'h08, h ? hc(ah) : hc(bh));
         end
      @(posedge clk_in);
      raw_in <= 4'hf;
      apb(1'b1, 12'h00c, 32'h6060);
      // Pin outputs are registered one cycle behind the control write
      @(negedge clk_in);
      chk("outputs", 4'h3, outs);
      apb(1'b1, 12'h00c, 32'h0);
      @(negedge clk_in);
      chk("outputs", 4'hc, outs);
      for (int k = 0; k < 3; k++) begin
         apb(1'b1, 12'h000, k == 2 ? 32'h4 : 32'h1);
         apb(1'b1, 12'h00c, k == 1 ? 32'h0 : 32'h10);
         chk("rtc", k == 0, rce);
      end
      $display("test control done");
      apb(1'b1, 12'h018, 32'h0);
      ev(11'h7ff);
      rdchk(12'h01c, 32'h70f);
      chk("irq", 32'h0, irq_out);
      apb(1'b1, 12'h018, 32'h100);
      chk("irq", 32'h1, irq_out);
      rdchk(12'h020, 32'h100);
      apb(1'b1, 12'h024, 32'h0);
      rdchk(12'h01c, 32'h70f);
      apb(1'b1, 12'h024, 32'h100);
      rdchk(12'h01c, 32'h60f);
      chk("irq", 32'h0, irq_out);
      apb(1'b1, 12'h024, 32'h70f);
      apb(1'b1, 12'h018, 32'h1);
      ev(11'h001);
      chk("irq", 32'h1, irq_out);
      // Event and clear of the same bit in one cycle: the event wins
      fork
         apb(1'b1, 12'h024, 32'h8);
         begin
            repeat (2) @(posedge clk_in);
            event_in <= 11'h008;
            @(posedge clk_in);
            event_in <= 11'h000;
         end
      join
      rdchk(12'h01c, 32'h9);
      $display("test interrupts done");
      stop_test();
   end
endmodule // gtm_regs_tb_top
